//--- include/rev_cfg.svh
/*
 * constants of the regulator enable and voltage register bank.
 * assumes one 125 mhz system clock and a byte-wide register port.
 */
`ifndef REV_CFG_SVH
`define REV_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define REV_OFS_BUCK_VOUT   8'h07
`define REV_OFS_LRA_CTRL    8'h08
`define REV_OFS_LRB_CTRL    8'h09
`define REV_OFS_LRA_VOUT    8'h0a
`define REV_OFS_LRB_VOUT    8'h0b

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define REV_RST_BUCK_VOUT   8'h59
`define REV_RST_LR_CTRL     8'h07
`define REV_RST_LR_VOUT     8'h19

// ----------------------------------------------------------------
// voltage code bands, in millivolts
// ----------------------------------------------------------------
`define REV_BUCK_LOW_CODE   12'h014
`define REV_BUCK_MID_CODE   12'h018
`define REV_BUCK_HIGH_CODE  12'h09e
`define REV_BUCK_LOW_MV     12'h2bc
`define REV_BUCK_MID_MV     12'h2df
`define REV_BUCK_HIGH_MV    12'h58c
`define REV_BUCK_LOW_STEP   12'h00a
`define REV_BUCK_MID_STEP   12'h005
`define REV_BUCK_HIGH_STEP  12'h014
`define REV_LR_BASE_MV      12'h320
`define REV_LR_STEP_MV      12'h064
`define REV_LR_MAX_CODE     5'h19

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define REV_CLK_MHZ         125
`define REV_DELAY_STEP_US   500

`endif

//--- include/rev_pkg.sv
/*
 * types of the regulator enable and voltage register bank.
 * assumes nothing beyond the config header.
 */
package rev_pkg;

   // ----------------------------------------------------------------
   // linear regulator control byte
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [4:0] rsvd;
      logic       discharge;
      logic       pin_sel;
      logic       enable;
   } rev_ctrl_type;

   // ----------------------------------------------------------------
   // pin sequencing states
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_OFF,
      SEQ_RISE,
      SEQ_ON,
      SEQ_FALL
   } rev_seq_type;

endpackage : rev_pkg

//--- logic/rev_regs.sv
/*
 * register bank for the second buck voltage code and two linear regulators:
 * storage, readback, voltage decode, pin-gated enables with delays, discharge.
 * assumes reg port and enable pin are synchronous to clk_sys; delay codes
 * come from the sequencing registers outside this bank.
 */
// Functional notes
// - buck codes 0x14-0x17 give 0.70-0.73 V in 10 mV; lower codes reserved
// - buck codes 0x18-0x9D give 0.735-1.4 V in 5 mV steps
// - buck codes 0x9E-0xFF give 1.42-3.36 V in 20 mV steps
// - buck voltage byte is read/write and resets to 0x59
// - linear regulator code 0 is 0.8 V, plus 100 mV per step to 0x19
// - linear regulator voltage bytes reset to 0x19, upper bits zero
// - control bit 0 enables the regulator, resets to one
// - control bit 1 adds the enable pin to the enable bit, resets to one
// - control bit 2 applies discharge while the regulator is off
// - pin rising edge starts regulator after startup delay, 0.5 ms per code
// - pin falling edge stops regulator after shutdown delay
`include "rev_cfg.svh"

module rev_regs #(
   parameter int STEP_CYCLES = `REV_DELAY_STEP_US * `REV_CLK_MHZ
) (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   output logic      [7:0]  reg_rdata,
   input  wire logic        en_pin,
   input  wire logic [3:0]  lr_start_code [2],
   input  wire logic [3:0]  lr_stop_code  [2],
   output logic      [11:0] second_buck_target_mv,
   output logic      [11:0] linreg_target_mv [2],
   output logic      [1:0]  linreg_enable,
   output logic      [1:0]  linreg_discharge
);

   if (STEP_CYCLES < 1 || STEP_CYCLES > 1000000) begin : g_bad_step
      $error("STEP_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   function automatic logic [11:0] buck_mv(input logic [7:0] code);
      logic [11:0] c;
      c = {4'h0, code};
      if (c < `REV_BUCK_LOW_CODE) begin
         buck_mv = `REV_BUCK_LOW_MV;
      end else if (c < `REV_BUCK_MID_CODE) begin
         buck_mv = `REV_BUCK_LOW_MV + `REV_BUCK_LOW_STEP * (c - `REV_BUCK_LOW_CODE);
      end else if (c < `REV_BUCK_HIGH_CODE) begin
         buck_mv = `REV_BUCK_MID_MV + `REV_BUCK_MID_STEP * (c - `REV_BUCK_MID_CODE);
      end else begin
         buck_mv = `REV_BUCK_HIGH_MV + `REV_BUCK_HIGH_STEP * (c - `REV_BUCK_HIGH_CODE);
      end
   endfunction : buck_mv

   function automatic logic [11:0] lr_mv(input logic [4:0] code);
      logic [4:0] c;
      c = (code > `REV_LR_MAX_CODE) ? `REV_LR_MAX_CODE : code;
      lr_mv = `REV_LR_BASE_MV + `REV_LR_STEP_MV * {7'h00, c};
   endfunction : lr_mv

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0]          buck_q;
   rev_pkg::rev_ctrl_type ctrl_q [2];
   logic [7:0]          vout_q [2];
   logic [7:0]          rdata_d;
   logic                first_q;
   wire  [7:0]          ctrl_ofs [2] = '{`REV_OFS_LRA_CTRL, `REV_OFS_LRB_CTRL};
   wire  [7:0]          vout_ofs [2] = '{`REV_OFS_LRA_VOUT, `REV_OFS_LRB_VOUT};

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         buck_q  <= `REV_RST_BUCK_VOUT;
         first_q <= 1'b0;
      end else begin
         first_q <= 1'b1;
         if (reg_wr && hit(reg_addr, `REV_OFS_BUCK_VOUT)) begin
            buck_q <= reg_wdata;
         end
      end
   end

   assign rdata_d = hit(reg_addr, `REV_OFS_BUCK_VOUT) ? buck_q :
                    hit(reg_addr, ctrl_ofs[0])        ? ctrl_q[0] :
                    hit(reg_addr, ctrl_ofs[1])        ? ctrl_q[1] :
                    hit(reg_addr, vout_ofs[0])        ? vout_q[0] :
                    hit(reg_addr, vout_ofs[1])        ? vout_q[1] : 8'h00;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata             <= 8'h00;
         second_buck_target_mv <= 12'h000;
      end else begin
         reg_rdata             <= rdata_d;
         second_buck_target_mv <= buck_mv(buck_q);
      end
   end

   a_buck_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
      reg_wr && reg_addr == `REV_OFS_BUCK_VOUT |=> buck_q == $past(reg_wdata))
      else $error("buck code write lost");
   a_reset_vals: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !first_q |-> buck_q == 8'h59 && vout_q[0] == 8'h19 && vout_q[1] == 8'h19
                   && ctrl_q[0] == 8'h07 && ctrl_q[1] == 8'h07)
      else $error("reset values wrong");
   a_read_back: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !reg_wr && reg_addr == `REV_OFS_BUCK_VOUT |=> reg_rdata == $past(buck_q))
      else $error("buck code readback wrong");
   a_buck_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
      buck_q >= 8'h14 && buck_q <= 8'h17
      |=> second_buck_target_mv == 12'd700 + 12'd10 * (12'($past(buck_q)) - 12'd20))
      else $error("buck low band decode wrong");
   a_buck_mid: assert property (@(posedge clk_sys) disable iff (sys_rst)
      buck_q >= 8'h18 && buck_q <= 8'h9d
      |=> second_buck_target_mv == 12'd735 + 12'd5 * (12'($past(buck_q)) - 12'd24))
      else $error("buck mid band decode wrong");
   a_buck_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
      buck_q >= 8'h9e |=> second_buck_target_mv
      == 12'd1420 + 12'd20 * (12'($past(buck_q)) - 12'd158))
      else $error("buck high band decode wrong");

   // ----------------------------------------------------------------
   // linear regulators
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_lr
         rev_pkg::rev_seq_type seq_q;
         rev_pkg::rev_seq_type seq_d;
         logic [23:0]          cnt_q;
         logic [23:0]          cnt_d;
         wire  [23:0]          start_cyc = 24'(lr_start_code[g]) * 24'(STEP_CYCLES);
         wire  [23:0]          stop_cyc  = 24'(lr_stop_code[g]) * 24'(STEP_CYCLES);
         wire                  pin_ok    = (seq_q == rev_pkg::SEQ_ON) ||
                                           (seq_q == rev_pkg::SEQ_FALL);
         wire                  eff_en    = ctrl_q[g].enable &&
                                           (!ctrl_q[g].pin_sel || pin_ok);

         always_comb begin
            seq_d = seq_q;
            cnt_d = cnt_q;
            case (seq_q)
               rev_pkg::SEQ_OFF: begin
                  if (en_pin) begin
                     cnt_d = start_cyc;
                     seq_d = (start_cyc == 24'h0) ? rev_pkg::SEQ_ON : rev_pkg::SEQ_RISE;
                  end
               end
               rev_pkg::SEQ_RISE: begin
                  if (!en_pin) begin
                     seq_d = rev_pkg::SEQ_OFF;
                  end else if (cnt_q <= 24'h1) begin
                     seq_d = rev_pkg::SEQ_ON;
                  end else begin
                     cnt_d = cnt_q - 24'h1;
                  end
               end
               rev_pkg::SEQ_ON: begin
                  if (!en_pin) begin
                     cnt_d = stop_cyc;
                     seq_d = (stop_cyc == 24'h0) ? rev_pkg::SEQ_OFF : rev_pkg::SEQ_FALL;
                  end
               end
               rev_pkg::SEQ_FALL: begin
                  if (en_pin) begin
                     seq_d = rev_pkg::SEQ_ON;
                  end else if (cnt_q <= 24'h1) begin
                     seq_d = rev_pkg::SEQ_OFF;
                  end else begin
                     cnt_d = cnt_q - 24'h1;
                  end
               end
               default: seq_d = rev_pkg::SEQ_OFF;
            endcase
         end

         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               ctrl_q[g]              <= `REV_RST_LR_CTRL;
               vout_q[g]              <= `REV_RST_LR_VOUT;
               seq_q                  <= rev_pkg::SEQ_OFF;
               cnt_q                  <= 24'h0;
               linreg_target_mv[g]    <= 12'h000;
               linreg_enable[g]       <= 1'b0;
               linreg_discharge[g]    <= 1'b0;
            end else begin
               if (reg_wr && hit(reg_addr, ctrl_ofs[g])) begin
                  ctrl_q[g] <= reg_wdata;
               end
               if (reg_wr && hit(reg_addr, vout_ofs[g])) begin
                  vout_q[g] <= reg_wdata;
               end
               seq_q               <= seq_d;
               cnt_q               <= cnt_d;
               linreg_target_mv[g] <= lr_mv(vout_q[g][4:0]);
               linreg_enable[g]    <= eff_en;
               linreg_discharge[g] <= ctrl_q[g].discharge && !eff_en;
            end
         end

         a_lr_decode: assert property (@(posedge clk_sys) disable iff (sys_rst)
            vout_q[g][4:0] <= 5'h19 |=> linreg_target_mv[g]
            == 12'd800 + 12'd100 * 12'($past(vout_q[g][4:0])))
            else $error("linear regulator decode wrong");
         a_bit_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
            !ctrl_q[g].pin_sel |=> linreg_enable[g] == $past(ctrl_q[g].enable))
            else $error("enable bit alone not obeyed");
         a_pin_gates: assert property (@(posedge clk_sys) disable iff (sys_rst)
            ctrl_q[g].pin_sel && seq_q == rev_pkg::SEQ_OFF |=> !linreg_enable[g])
            else $error("pin gate ignored");
         a_discharge_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
            ##1 linreg_discharge[g] |-> !linreg_enable[g] && $past(ctrl_q[g].discharge))
            else $error("discharge while enabled");
         a_start_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
            seq_q == rev_pkg::SEQ_OFF && en_pin && lr_start_code[g] != 4'h0
            |=> seq_q == rev_pkg::SEQ_RISE ##1 seq_q != rev_pkg::SEQ_ON || STEP_CYCLES == 1)
            else $error("startup delay skipped");
         a_stop_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
            seq_q == rev_pkg::SEQ_ON && !en_pin && lr_stop_code[g] != 4'h0
            |=> seq_q == rev_pkg::SEQ_FALL)
            else $error("shutdown delay skipped");
      end
   endgenerate

endmodule : rev_regs

//--- tb/rev_regs_tb.sv
/*
 * self-checking bench for the regulator enable and voltage register bank.
 * assumes rev_regs built with STEP_CYCLES of 4 and a 125 mhz clk_sys.
 */
`include "rev_cfg.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [2:0]  kind;
      logic [11:0] exp;
   } rev_note_type;

   // ----------------------------------------------------------------
   // signals and design
   // ----------------------------------------------------------------
   logic         clk_sys = 1'b0;
   logic         sys_rst = 1'b1;
   logic [7:0]   reg_addr = 8'h00;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr = 1'b0;
   logic [7:0]   reg_rdata;
   logic         en_pin = 1'b0;
   logic [3:0]   lr_start_code [2] = '{4'h2, 4'h0};
   logic [3:0]   lr_stop_code  [2] = '{4'h1, 4'h3};
   logic [11:0]  second_buck_target_mv;
   logic [11:0]  linreg_target_mv [2];
   logic [1:0]   linreg_enable;
   logic [1:0]   linreg_discharge;
   rev_note_type q [$];
   rev_note_type n;
   int           note_cnt = 0;
   int           err_count = 0;
   int           check_count = 0;
   logic [31:0]  rnd = 32'h205c3be7;
   logic [7:0]   ca;
   logic [7:0]   cb;
   logic [7:0]   edges [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};

   always #4 clk_sys = ~clk_sys;

   rev_regs #(.STEP_CYCLES(4)) dut (
      .clk_sys               (clk_sys),
      .sys_rst               (sys_rst),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rdata             (reg_rdata),
      .en_pin                (en_pin),
      .lr_start_code         (lr_start_code),
      .lr_stop_code          (lr_stop_code),
      .second_buck_target_mv (second_buck_target_mv),
      .linreg_target_mv      (linreg_target_mv),
      .linreg_enable         (linreg_enable),
      .linreg_discharge      (linreg_discharge)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [11:0] buck_mv(input logic [7:0] c);
      if (c <= 8'h17) return 12'd700 + 12'd10 * (c - 8'h14);
      if (c <= 8'h9d) return 12'd735 + 12'd5 * (c - 8'h18);
      return 12'd1420 + 12'd20 * (c - 8'h9e);
   endfunction : buck_mv

   function automatic logic [11:0] lr_mv(input logic [7:0] c);
      return 12'd800 + 12'd100 * c;
   endfunction : lr_mv

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : tick

   task automatic note(input logic [2:0] k, input logic [11:0] e);
      q.push_back(rev_note_type'{kind: k, exp: e});
      note_cnt++;
   endtask : note

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_addr = a;
      tick(1);
      note(3'd0, {4'h0, e});
   endtask : rd

   task automatic fail(input logic [11:0] e, input logic [11:0] g);
      err_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
   endtask : fail

   task automatic cmp_byte(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) fail({4'h0, e}, {4'h0, g});
   endtask : cmp_byte

   task automatic cmp_mv(input logic [11:0] e, input logic [11:0] g);
      check_count++;
      if (g !== e) fail(e, g);
   endtask : cmp_mv

   task automatic cmp_pair(input logic [1:0] e, input logic [1:0] g);
      check_count++;
      if (g !== e) fail({10'h000, e}, {10'h000, g});
   endtask : cmp_pair

   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // ----------------------------------------------------------------
   // monitor: oldest note against the matching output
   // ----------------------------------------------------------------
   always @(note_cnt) begin
      while (q.size() > 0) begin
         n = q.pop_front();
         case (n.kind)
            3'd0: cmp_byte(n.exp[7:0], reg_rdata);
            3'd1: cmp_mv(n.exp, second_buck_target_mv);
            3'd2: cmp_mv(n.exp, linreg_target_mv[0]);
            3'd3: cmp_mv(n.exp, linreg_target_mv[1]);
            3'd4: cmp_pair(n.exp[1:0], linreg_enable);
            default: cmp_pair(n.exp[1:0], linreg_discharge);
         endcase
      end
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_count++;
      $display("watchdog expired");
      complete_run();
   end

   // ----------------------------------------------------------------
   // stimulus
   // ----------------------------------------------------------------
   initial begin
      tick(20);
      sys_rst = 1'b0;
      rd(8'h07, 8'h59);
      rd(8'h08, 8'h07);
      rd(8'h09, 8'h07);
      rd(8'h0a, 8'h19);
      rd(8'h0b, 8'h19);
      note(3'd1, 12'd1060);
      note(3'd2, 12'd3300);
      note(3'd3, 12'd3300);
      note(3'd4, 12'h000);
      note(3'd5, 12'h003);
      $display("test reset done");
      for (int i = 0; i < 14; i++) begin
         rnd = lfsr_next(rnd);
         ca = (i < 6) ? edges[i] : 8'h14 + 8'(rnd % 236);
         wr(8'h07, ca);
         tick(1);
         rd(8'h07, ca);
         note(3'd1, buck_mv(ca));
      end
      $display("test buck decode done");
      for (int i = 0; i < 10; i++) begin
         rnd = lfsr_next(rnd);
         ca = (i == 0) ? 8'h00 : (i == 1) ? 8'h19 : 8'(rnd % 26);
         cb = 8'(rnd[15:8] % 26);
         wr(8'h0a, ca);
         wr(8'h0b, cb);
         tick(1);
         note(3'd2, lr_mv(ca));
         note(3'd3, lr_mv(cb));
         rd(8'h0a, ca);
         rd(8'h0b, cb);
      end
      $display("test linear decode done");
      foreach (edges[i]) begin
         cb = {5'h00, edges[i][2:0]};
         wr(8'h08, cb);
         wr(8'h09, cb);
         tick(1);
         note(3'd4, {10'h000, {2{cb[0] & ~cb[1]}}});
         note(3'd5, {10'h000, {2{cb[2] & ~(cb[0] & ~cb[1])}}});
      end
      $display("test enable bits done");
      wr(8'h0c, 8'h5a);
      rd(8'h0c, 8'h00);
      rd(8'h20, 8'h00);
      rd(8'h0a, ca);
      $display("test unmapped done");
      wr(8'h08, 8'h07);
      wr(8'h09, 8'h07);
      tick(2);
      en_pin = 1'b1;
      tick(9);
      note(3'd4, 12'h002);
      tick(1);
      note(3'd4, 12'h003);
      note(3'd5, 12'h000);
      en_pin = 1'b0;
      tick(5);
      note(3'd4, 12'h003);
      tick(1);
      note(3'd4, 12'h002);
      tick(7);
      note(3'd4, 12'h002);
      tick(1);
      note(3'd4, 12'h000);
      note(3'd5, 12'h003);
      $display("test pin sequence done");
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      rd(8'h07, 8'h59);
      rd(8'h0a, 8'h19);
      rd(8'h08, 8'h07);
      $display("test mid reset done");
      tick(1);
      complete_run();
   end

endmodule : tb
